/* File: include/sfcl_pkg.sv */
// package for the serial front-end configuration loader
// assumes both ends and the bench import it whole
package sfcl_pkg;
  // ==========================================================================
  // word layout
  localparam int WORD_W        = 7;
  localparam int IMP_LSB       = 0;
  localparam int IMP_W         = 2;
  localparam int FEEDBACK_BIT  = 2;
  localparam int HIGH_GAIN_BIT = 3;
  localparam int FILT_LSB      = 4;
  localparam int FILT_W        = 2;
  localparam int SPARE_BIT     = 6;
  // ==========================================================================
  // decoded settings
  typedef enum logic [2:0] {
    SFCL_Z_50, SFCL_Z_100, SFCL_Z_200, SFCL_Z_400,
    SFCL_Z_1000, SFCL_Z_2000, SFCL_Z_OPEN
  } sfcl_imp_e;
  typedef enum logic [1:0] {
    SFCL_FC_9MHZ, SFCL_FC_10MHZ, SFCL_FC_15MHZ, SFCL_FC_18MHZ
  } sfcl_filt_e;
  typedef enum logic [1:0] {
    SFCL_PWR_NORMAL, SFCL_PWR_STANDBY, SFCL_PWR_DOWN
  } sfcl_pwr_e;
  // ==========================================================================
  // host side: register offsets and divider
  localparam logic [1:0] REG_WORD   = 2'h0;
  localparam logic [1:0] REG_CTRL   = 2'h1;
  localparam logic [1:0] REG_STATUS = 2'h2;
  localparam int CTRL_GO_BIT    = 0;
  localparam int CTRL_PD_BIT    = 1;
  localparam int CTRL_SB_BIT    = 2;
  localparam int LINK_DIV_HALF  = 5;
  localparam int GUARD_HALVES   = 2;
endpackage

/* File: include/sfcl_if.sv */
// interface carrying the serial programming link and mode pins
// assumes the host drives every signal except the serial data out
`timescale 1ns/10ps
interface sfcl_if;
  logic sclk;
  logic sdin;
  logic sel_n;
  logic sdout;
  logic power_down_pin;
  logic standby_pin;
  modport device (input sclk, sdin, sel_n, power_down_pin, standby_pin,
                  output sdout);
  modport host (output sclk, sdin, sel_n, power_down_pin, standby_pin,
                input sdout);
endinterface

/* File: logic/sfcl_device.sv */
// device end: shift register, operating register and mode decode
// assumes the host keeps the select protocol; runs on the link clock and the select rising edge only
//
// Notes on behaviour
// - host programs before relying on modes
// - bit 3 picks high or low gain
// - high gain impedance 50/100/200/1000 ohm
// - low gain impedance 100/200/400/2000 ohm
// - bits 3,2 set give open feedback
// - bits 5:4 pick filter corner, bit 6 ignored
// - host lowers select before data bits
// - host raises select after whole word
// - host shifts least significant bit first
// - select rising edge loads operating register
// - shifted-out bits appear on data out
// - one shared select updates whole chain
// - power-down pin high powers device down
// - standby pin high gives biased standby
// - data sampled on serial clock rising edge
// - power-down outranks standby
// - standby overrides soft channel shutdown
`timescale 1ns/10ps
module sfcl_device
  import sfcl_pkg::*;
(
  sfcl_if.device              link,
  output logic [WORD_W-1:0]   channel_config_word_out,
  output logic                high_gain_bit_out,
  output sfcl_imp_e           impedance_out,
  output sfcl_filt_e          filter_corner_out,
  output sfcl_pwr_e           power_mode_out,
  output logic                soft_shutdown_allowed_out,
  output logic                programmed_out
);
  // ==========================================================================
  // shift register
  logic [WORD_W-1:0] shift_r;
  logic              sdout_r;

  always_ff @(posedge link.sclk) begin
    if (!link.sel_n) begin
      shift_r <= {link.sdin, shift_r[WORD_W-1:1]};
      sdout_r <= shift_r[0];
    end
  end
  assign link.sdout = sdout_r;

  // ==========================================================================
  // operating register, loaded on select rising edge
  logic [WORD_W-1:0] word_r;
  logic              prog_r;

  always_ff @(posedge link.sel_n) begin
    word_r <= shift_r;
    prog_r <= 1'b1;
  end

  // ==========================================================================
  // decode of the held word into settings
  logic [WORD_W-1:0] word_q;
  sfcl_imp_e         imp_nxt;

  always_comb begin
    word_q = word_r;
    case ({word_q[HIGH_GAIN_BIT], word_q[FEEDBACK_BIT],
           word_q[IMP_LSB+:IMP_W]})
      4'h8:    imp_nxt = SFCL_Z_50;
      4'h9:    imp_nxt = SFCL_Z_100;
      4'hA:    imp_nxt = SFCL_Z_200;
      4'hB:    imp_nxt = SFCL_Z_1000;
      4'h0:    imp_nxt = SFCL_Z_100;
      4'h1:    imp_nxt = SFCL_Z_200;
      4'h2:    imp_nxt = SFCL_Z_400;
      4'h3:    imp_nxt = SFCL_Z_2000;
      4'hC, 4'hD, 4'hE, 4'hF:
               imp_nxt = SFCL_Z_OPEN;
      default: imp_nxt = SFCL_Z_OPEN;
    endcase
  end

  assign channel_config_word_out = word_r;
  assign programmed_out          = prog_r;
  assign high_gain_bit_out       = word_r[HIGH_GAIN_BIT];
  assign impedance_out           = imp_nxt;
  assign filter_corner_out       =
    sfcl_filt_e'(word_r[FILT_LSB+:FILT_W]);

  // ==========================================================================
  // power modes from the pins
  always_comb begin
    if (link.power_down_pin)
      power_mode_out = SFCL_PWR_DOWN;
    else if (link.standby_pin)
      power_mode_out = SFCL_PWR_STANDBY;
    else
      power_mode_out = SFCL_PWR_NORMAL;
  end
  assign soft_shutdown_allowed_out =
    (power_mode_out == SFCL_PWR_NORMAL);
endmodule // sfcl_device

/* File: logic/sfcl_host.sv */
// host end: register port, link clock divider and word shifter
// assumes software uses the plain strobe port on clk_in
`timescale 1ns/10ps
module sfcl_host
  import sfcl_pkg::*;
#(
  parameter int DIV_HALF = LINK_DIV_HALF
)(
  input  wire logic              clk_in,
  input  wire logic              reset_n_in,
  input  wire logic [1:0]        addr_in,
  input  wire logic [7:0]        wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [7:0]        rdata_out,
  sfcl_if.host                   link
);
  initial if (DIV_HALF < 1 || DIV_HALF > 256) $error("DIV_HALF out of range");

  typedef enum {ST_IDLE, ST_SEL, ST_SHIFT, ST_GUARD} sfcl_hst_e;
  sfcl_hst_e         st_r;
  logic [WORD_W-1:0] word_r, shreg_r;
  logic              pd_r, sb_r, busy_r, sclk_r, sdin_r, sel_n_r;
  logic [7:0]        div_r;
  logic [3:0]        half_r;
  logic [1:0]        sdo_sync_r;
  logic              tick;

  assign tick = (div_r == 8'(DIV_HALF - 1));
  // ==========================================================================
  // divider
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) div_r <= 8'h00;
    else if (tick || st_r == ST_IDLE) div_r <= 8'h00;
    else div_r <= div_r + 8'h01;
  end
  // ==========================================================================
  // registers
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      word_r <= '0;
      pd_r   <= 1'b0;
      sb_r   <= 1'b0;
    end else if (wr_in && addr_in == REG_WORD) begin
      word_r <= wdata_in[WORD_W-1:0];
    end else if (wr_in && addr_in == REG_CTRL) begin
      pd_r <= wdata_in[CTRL_PD_BIT];
      sb_r <= wdata_in[CTRL_SB_BIT];
    end
  end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) sdo_sync_r <= 2'h0;
    else sdo_sync_r <= {sdo_sync_r[0], link.sdout};
  end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) rdata_out <= 8'h00;
    else if (rd_in) begin
      case (addr_in)
        REG_WORD:   rdata_out <= {1'b0, word_r};
        REG_CTRL:   rdata_out <= {5'h00, sb_r, pd_r, 1'b0};
        REG_STATUS: rdata_out <= {6'h00, sdo_sync_r[1], busy_r};
        default:    rdata_out <= 8'h00;
      endcase
    end else rdata_out <= 8'h00;
  end
  // ==========================================================================
  // shifter: select low, seven clocks, select high
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_r <= ST_IDLE; sclk_r <= 1'b0; sdin_r <= 1'b0; sel_n_r <= 1'b1;
      half_r <= 4'h0; shreg_r <= '0; busy_r <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: if (wr_in && addr_in == REG_CTRL && wdata_in[CTRL_GO_BIT]) begin
          busy_r <= 1'b1; shreg_r <= word_r; st_r <= ST_SEL;
          sel_n_r <= 1'b0;
        end
        ST_SEL: if (tick) begin
          sdin_r  <= shreg_r[0];
          shreg_r <= shreg_r >> 1;
          half_r  <= 4'h0;
          st_r    <= ST_SHIFT;
        end
        ST_SHIFT: if (tick) begin
          sclk_r <= ~sclk_r;
          half_r <= half_r + 4'h1;
          if (sclk_r) begin
            sdin_r  <= shreg_r[0];
            shreg_r <= shreg_r >> 1;
          end
          if (half_r == 4'(2*WORD_W - 1)) begin
            st_r <= ST_GUARD;
            half_r <= 4'h0;
          end
        end
        ST_GUARD: if (tick) begin
          half_r <= half_r + 4'h1;
          if (half_r == 4'(GUARD_HALVES - 1)) begin
            sel_n_r <= 1'b1;
            busy_r  <= 1'b0;
            st_r    <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end
  assign link.sclk           = sclk_r;
  assign link.sdin           = sdin_r;
  assign link.sel_n          = sel_n_r;
  assign link.power_down_pin = pd_r;
  assign link.standby_pin    = sb_r;
endmodule // sfcl_host

/* File: testbench/sfcl_assertions.sv */
// checker for the serial programming link
// assumes the link signals plus the host clock and reset
`timescale 1ns/10ps
module sfcl_assertions #(parameter int DIV_HALF = 5) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic sclk,
  input wire logic sdin,
  input wire logic sel_n,
  input wire logic sdout,
  input wire logic power_down_pin,
  input wire logic standby_pin
);
  // ====
  // frame and history counters
  logic [7:0] low_r;
  logic [3:0] rise_r, seen_r;
  logic [6:0] hist_r;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      low_r <= 8'h00;
      rise_r <= 4'h0;
    end else if (sel_n) begin
      low_r <= 8'h00;
      rise_r <= 4'h0;
    end else begin
      low_r <= low_r + 8'h01;
      rise_r <= rise_r + 4'($rose(sclk));
    end
  end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hist_r <= 7'h00;
      seen_r <= 4'h0;
    end else if ($rose(sclk)) begin
      hist_r <= {hist_r[5:0], sdin};
      seen_r <= (seen_r == 4'h7) ? 4'h7 : seen_r + 4'h1;
    end
  end
  // ====
  // assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  AST_SCLK_IDLE: assert property (sel_n |-> !sclk)
    else $error("serial clock moves outside a frame");
  AST_SEL_LEAD: assert property ($fell(sel_n) |-> !sclk [*4])
    else $error("clock edge too soon after select");
  AST_FRAME_LEN: assert property ($rose(sel_n) |-> low_r == 8'(17 * DIV_HALF))
    else $error("select low time wrong");
  AST_SEVEN_RISES: assert property ($rose(sel_n) |-> rise_r == 4'h7)
    else $error("frame not seven bits");
  AST_SDIN_STABLE: assert property ($rose(sclk) |-> $stable(sdin))
    else $error("data moves at clock rise");
  AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk [*5] ##1 !sclk)
    else $error("clock high half wrong");
  AST_SDOUT_EDGE: assert property ($changed(sdout) |-> $rose(sclk) && !sel_n)
    else $error("data out moved off a shift edge");
  AST_SDOUT_DISPLACED: assert property ($rose(sclk) && seen_r == 4'h7 |-> sdout == hist_r[6])
    else $error("data out not the displaced bit");
  COV_FRAME: cover property ($rose(sel_n));
  COV_DOWN: cover property ($rose(power_down_pin));
  COV_STANDBY: cover property ($rose(standby_pin) && !power_down_pin);
endmodule // sfcl_assertions

/* File: testbench/tb_serial_front_end_config_loader.sv */
// bench joining host and device ends over the link
// assumes 125 MHz clk_in; host divides it to an 80 ns link clock
`timescale 1ns/10ps
module tb_serial_front_end_config_loader import sfcl_pkg::*;;
  logic clk_in, reset_n_in, wr, rd, hg, prog, soft_ok;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [6:0] word;
  sfcl_imp_e imp;
  sfcl_filt_e filt;
  sfcl_pwr_e pwr;
  int fail_count = 0, n_compared = 0, cyc = 0;
  typedef struct {logic [6:0] w; sfcl_imp_e z; sfcl_filt_e f;} sfcl_row_s;
  sfcl_row_s rows [10] = '{'{7'h08, SFCL_Z_50, SFCL_FC_9MHZ},
    '{7'h19, SFCL_Z_100, SFCL_FC_10MHZ}, '{7'h2A, SFCL_Z_200, SFCL_FC_15MHZ},
    '{7'h7B, SFCL_Z_1000, SFCL_FC_18MHZ}, '{7'h00, SFCL_Z_100, SFCL_FC_9MHZ},
    '{7'h51, SFCL_Z_200, SFCL_FC_10MHZ}, '{7'h22, SFCL_Z_400, SFCL_FC_15MHZ},
    '{7'h33, SFCL_Z_2000, SFCL_FC_18MHZ}, '{7'h0F, SFCL_Z_OPEN, SFCL_FC_9MHZ},
    '{7'h4E, SFCL_Z_OPEN, SFCL_FC_9MHZ}};
  sfcl_if link_i();
  sfcl_host #(.DIV_HALF(5)) i_sfcl_host (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .link(link_i));
  sfcl_device i_sfcl_device (.link(link_i), .channel_config_word_out(word),
    .high_gain_bit_out(hg), .impedance_out(imp), .filter_corner_out(filt),
    .power_mode_out(pwr), .soft_shutdown_allowed_out(soft_ok),
    .programmed_out(prog));
  sfcl_assertions #(.DIV_HALF(5)) i_sfcl_assertions (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .sclk(link_i.sclk), .sdin(link_i.sdin),
    .sel_n(link_i.sel_n), .sdout(link_i.sdout),
    .power_down_pin(link_i.power_down_pin), .standby_pin(link_i.standby_pin));
  // ====
  // tasks
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (e !== g) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(logic [1:0] a, logic [7:0] v);
    @(posedge clk_in);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [1:0] a);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_idle();
    repeat (2) @(posedge clk_in);
    for (int i = 0; i < 100; i++) begin
      rd_reg(REG_STATUS);
      if (d[0] === 1'b0) break;
    end
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ====
  // clock, timeout and tests
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    reset_n_in = 1'b0;
    {wr, rd, addr, wdata} = 12'h000;
    repeat (3) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd_reg(REG_STATUS);
    chk("busy", 8'h00, {7'h00, d[0]});
    chk("sel_n", 8'h01, {7'h00, link_i.sel_n});
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      wr_reg(REG_WORD, {1'b0, rows[i].w});
      wr_reg(REG_CTRL, 8'h01);
      wait_idle();
      chk("word", {1'b0, rows[i].w}, {1'b0, word});
      chk("gain", {7'h00, rows[i].w[3]}, {7'h00, hg});
      chk("imp", 8'(rows[i].z), 8'(imp));
      chk("filt", 8'(rows[i].f), 8'(filt));
      if (i > 0)
        chk("sdout", {7'h00, rows[i-1].w[6]}, {7'h00, d[1]});
    end
    chk("prog", 8'h01, {7'h00, prog});
    rd_reg(REG_WORD);
    chk("word reg", {1'b0, rows[9].w}, d);
    $display("test rows done");
    for (int m = 0; m < 4; m++) begin
      wr_reg(REG_CTRL, 8'(m << 1));
      repeat (4) @(posedge clk_in);
      chk("mode", 8'(m[0] ? SFCL_PWR_DOWN : m[1] ? SFCL_PWR_STANDBY :
        SFCL_PWR_NORMAL), 8'(pwr));
      chk("soft", {7'h00, m == 0}, {7'h00, soft_ok});
      rd_reg(REG_CTRL);
      chk("ctrl reg", 8'(m << 1), d);
    end
    wr_reg(REG_CTRL, 8'h00);
    $display("test power modes done");
    wr_reg(REG_WORD, 8'h15);
    wr_reg(REG_CTRL, 8'h01);
    wr_reg(REG_WORD, 8'h6A);
    wr_reg(REG_CTRL, 8'h01);
    wait_idle();
    chk("word", 8'h15, {1'b0, word});
    wr_reg(REG_CTRL, 8'h01);
    wait_idle();
    chk("word", 8'h6A, {1'b0, word});
    rd_reg(2'h3);
    chk("unmapped", 8'h00, d);
    $display("test busy refusal done");
    results();
  end
endmodule // tb_serial_front_end_config_loader
